/* hdl/scst_core.sv */
// smart card half-duplex serial transfer with apb registers
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module scst_core
    import scst_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // card line and clock
    input wire logic rx_data_pin,
    output logic tx_data_pin_o,
    output logic tx_data_pin_oe,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    // requests
    output logic tx_empty_request,
    output logic rx_full_request,
    output logic transfer_fault_request,
    output logic tx_end_request
);
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
        begin
            rev8[i] = v[7 - i];
        end
    endfunction

    scst_state_t st_q, st_d;
    logic [7:0] mode_q, mode_d, div_q, div_d, ctrl_q, ctrl_d, card_q, card_d;
    logic [7:0] txd_q, txd_d, rxd_q, rxd_d, stat_q, stat_d;
    logic [14:0] pre_q, pre_d, half;
    logic sck_q, sck_d, tick, samp;
    logic [8:0] cnt_q, cnt_d;
    logic [3:0] slot_q, slot_d;
    logic [9:0] txf_q, txf_d, rxb_q, rxb_d;
    logic bad_q, bad_d, oe_q, oe_d, cko_q, cko_d;
    logic rx_m_q, rx_s_q, rx_p_q, rx_p_d;
    logic rdy_q, rdy_d, err_q, err_d;
    logic [7:0] rd_q, rd_d, hw_set, hw_clr, sw_clr, ord, wb;
    logic txe_q, txe_d, rxf_q, rxf_d, flt_q, flt_d;
    logic acc, wr, par_bad;

    always_comb
    begin
        acc = psel && penable && rdy_q;
        wr = acc && pwrite;
        wb = pwdata[7:0];
        mode_d = mode_q;
        div_d = div_q;
        ctrl_d = ctrl_q;
        card_d = card_q;
        txd_d = txd_q;
        rxd_d = rxd_q;
        sw_clr = 8'h00;
        hw_set = 8'h00;
        hw_clr = 8'h00;
        rd_d = rd_q;
        err_d = 1'b0;
        rdy_d = psel && penable && !rdy_q;
        if (rdy_d)
        begin
            unique case (paddr)
                OFS_MODE: rd_d = mode_q;
                OFS_DIV: rd_d = div_q;
                OFS_CTRL: rd_d = ctrl_q;
                OFS_TXD: rd_d = txd_q;
                OFS_STAT: rd_d = stat_q;
                OFS_RXD: rd_d = rxd_q;
                OFS_CARD: rd_d = card_q;
                default:
                begin
                    rd_d = 8'h00;
                    err_d = 1'b1;
                end
            endcase
        end
        if (wr)
        begin
            unique case (paddr)
                OFS_MODE: mode_d = wb;
                OFS_DIV: div_d = wb;
                OFS_CTRL: ctrl_d = wb;
                OFS_TXD: txd_d = wb;
                OFS_STAT: sw_clr = ~wb & SS_SWCLR;
                OFS_CARD: card_d = wb;
                default: ;
            endcase
        end
        // base clock divider, one tick per 2*4^n*(N+1) cycles
        half = (15'({7'h00, div_q}) + 15'h0001) << {mode_q[MD_CKS+:2], 1'b0};
        pre_d = pre_q + 15'h0001;
        sck_d = sck_q;
        tick = 1'b0;
        if (!card_q[CD_CARD_MODE_SELECT])
        begin
            pre_d = 15'h0000;
            sck_d = 1'b0;
        end
        else if (pre_q == half - 15'h0001)
        begin
            pre_d = 15'h0000;
            sck_d = ~sck_q;
            tick = sck_q;
        end
        // clock pin driven only with clock output enabled
        cko_d = ctrl_q[CT_CKO] && card_q[CD_CARD_MODE_SELECT];
        // sample strobe on the 186th tick of each bit
        samp = tick && (cnt_q == SAMPLE_CNT);
        rx_p_d = tick ? rx_s_q : rx_p_q;
        cnt_d = cnt_q;
        slot_d = slot_q;
        if (tick)
        begin
            cnt_d = (cnt_q == BIT_LAST) ? 9'h000 : cnt_q + 9'h001;
            slot_d = (cnt_q == BIT_LAST) ? slot_q + 4'h1 : slot_q;
        end
        st_d = st_q;
        txf_d = txf_q;
        rxb_d = rxb_q;
        bad_d = bad_q;
        ord = rev8(txd_q ^ {8{card_q[CD_DATA_INVERT_SELECT]}});
        if (!card_q[CD_BIT_ORDER_SELECT])
        begin
            ord = txd_q ^ {8{card_q[CD_DATA_INVERT_SELECT]}};
        end
        par_bad = (^{rx_s_q, rxb_q[8:1]}) != mode_q[MD_ODD];
        unique case (st_q)
            ST_IDLE:
            begin
                cnt_d = 9'h000;
                slot_d = 4'h0;
                bad_d = 1'b0;
                if (card_q[CD_CARD_MODE_SELECT] && ctrl_q[CT_TE] && !stat_q[SS_TX_BUFFER_EMPTY_FLAG])
                begin
                    st_d = ST_SEND;
                    txf_d = {(^ord) ^ mode_q[MD_ODD], ord, 1'b0};
                    hw_set[SS_TX_BUFFER_EMPTY_FLAG] = 1'b1;
                    hw_clr[SS_TX_DONE_FLAG] = 1'b1;
                end
                else if (card_q[CD_CARD_MODE_SELECT] && ctrl_q[CT_RE] && tick && rx_p_q && !rx_s_q)
                begin
                    st_d = ST_RECV;
                    cnt_d = 9'h001;
                end
            end
            ST_SEND:
            begin
                if (tick && slot_q == SLOT_CHK && cnt_q == 9'h000 && !rx_s_q)
                begin
                    bad_d = 1'b1;
                    hw_set[SS_ERS] = 1'b1;
                end
                if (tick && slot_q == SLOT_END && cnt_q == BIT_LAST)
                begin
                    slot_d = 4'h0;
                    bad_d = 1'b0;
                    if (!bad_q)
                    begin
                        st_d = ST_IDLE;
                        hw_set[SS_TX_DONE_FLAG] = 1'b1;
                    end
                end
                if (!ctrl_q[CT_TE] || !card_q[CD_CARD_MODE_SELECT])
                begin
                    st_d = ST_IDLE;
                end
            end
            ST_RECV:
            begin
                if (samp && slot_q <= SLOT_PAR)
                begin
                    rxb_d[slot_q] = rx_s_q;
                end
                if (samp && slot_q == 4'h0 && rx_s_q)
                begin
                    st_d = ST_IDLE;
                end
                if (samp && slot_q == SLOT_PAR)
                begin
                    bad_d = par_bad;
                    ord = card_q[CD_BIT_ORDER_SELECT] ? rev8(rxb_q[8:1]) : rxb_q[8:1];
                    if (par_bad)
                    begin
                        // parity flag set, full flag untouched
                        hw_set[SS_PER] = 1'b1;
                        rxd_d = ord ^ {8{card_q[CD_DATA_INVERT_SELECT]}};
                    end
                    else if (stat_q[SS_RX_FULL_FLAG])
                    begin
                        hw_set[SS_OVERRUN_FLAG] = 1'b1;
                    end
                    else
                    begin
                        hw_set[SS_RX_FULL_FLAG] = 1'b1;
                        rxd_d = ord ^ {8{card_q[CD_DATA_INVERT_SELECT]}};
                    end
                end
                if ((tick && slot_q == SLOT_CHK && cnt_q == BIT_LAST) || !ctrl_q[CT_RE]
                    || !card_q[CD_CARD_MODE_SELECT])
                begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // hardware set wins over software clear
        stat_d = ((stat_q & ~sw_clr & ~hw_clr) | hw_set) & 8'hFC;
        // data pin released unless driving a low level
        oe_d = 1'b0;
        if (st_q == ST_SEND && slot_q <= SLOT_PAR)
        begin
            oe_d = !txf_q[slot_q];
        end
        // error pulse, half bit after parity, none if good
        if (st_q == ST_RECV && bad_q)
        begin
            oe_d = (slot_q == SLOT_ERR && cnt_q >= HALF_CNT)
                || (slot_q == SLOT_CHK && cnt_q < HALF_CNT);
        end
        txe_d = stat_q[SS_TX_DONE_FLAG] && ctrl_q[CT_TIE];
        rxf_d = stat_q[SS_RX_FULL_FLAG] && ctrl_q[CT_RIE];
        // fault request gated by receive interrupt enable
        flt_d = (stat_q[SS_OVERRUN_FLAG] || stat_q[SS_PER] || stat_q[SS_ERS]) && ctrl_q[CT_RIE];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= ST_IDLE;
            mode_q <= MODE_RST;
            div_q <= DIV_RST;
            ctrl_q <= CTRL_RST;
            card_q <= CARD_RST;
            stat_q <= STAT_RST;
            txd_q <= 8'h00;
            rxd_q <= 8'h00;
            pre_q <= 15'h0000;
            sck_q <= 1'b0;
            cnt_q <= 9'h000;
            slot_q <= 4'h0;
            txf_q <= 10'h3FF;
            rxb_q <= 10'h000;
            bad_q <= 1'b0;
            oe_q <= 1'b0;
            cko_q <= 1'b0;
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
            rx_p_q <= 1'b1;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            rd_q <= 8'h00;
            txe_q <= 1'b0;
            rxf_q <= 1'b0;
            flt_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            mode_q <= mode_d;
            div_q <= div_d;
            ctrl_q <= ctrl_d;
            card_q <= card_d;
            stat_q <= stat_d;
            txd_q <= txd_d;
            rxd_q <= rxd_d;
            pre_q <= pre_d;
            sck_q <= sck_d;
            cnt_q <= cnt_d;
            slot_q <= slot_d;
            txf_q <= txf_d;
            rxb_q <= rxb_d;
            bad_q <= bad_d;
            oe_q <= oe_d;
            cko_q <= cko_d;
            rx_m_q <= rx_data_pin;
            rx_s_q <= rx_m_q;
            rx_p_q <= rx_p_d;
            rdy_q <= rdy_d;
            err_q <= err_d;
            rd_q <= rd_d;
            txe_q <= txe_d;
            rxf_q <= rxf_d;
            flt_q <= flt_d;
        end
    end

    assign prdata = {24'h000000, rd_q};
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign tx_data_pin_o = 1'b0;
    assign tx_data_pin_oe = oe_q;
    assign serial_clock_pin_o = sck_q;
    assign serial_clock_pin_oe = cko_q;
    assign tx_empty_request = txe_q;
    assign rx_full_request = rxf_q;
    assign transfer_fault_request = flt_q;
    assign tx_end_request = 1'b0;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_tx_start;
        st_q == ST_IDLE && st_d == ST_SEND;
    endsequence
    sequence s_err_begin;
        st_q == ST_RECV && bad_q && slot_q == SLOT_ERR && cnt_q == HALF_CNT;
    endsequence

    a_tx_done_flag_clear: assert property (s_tx_start |=> !stat_q[SS_TX_DONE_FLAG] && stat_q[SS_TX_BUFFER_EMPTY_FLAG])
        else $error("done flag not cleared at send start");
    a_clock_gate: assert property (!ctrl_q[CT_CKO] |=> !serial_clock_pin_oe)
        else $error("clock driven while disabled");
    a_no_tx_done_flag_req: assert property (!tx_end_request)
        else $error("transmit end request raised");
    a_txe_request: assert property ($rose(stat_q[SS_TX_DONE_FLAG]) && ctrl_q[CT_TIE] |=> tx_empty_request)
        else $error("empty request missing");
    a_rxf_request: assert property ($rose(stat_q[SS_RX_FULL_FLAG]) && ctrl_q[CT_RIE] |=> rx_full_request)
        else $error("full request missing");
    a_fault_request: assert property ((stat_q[SS_PER] || stat_q[SS_ERS]) && ctrl_q[CT_RIE]
        |=> transfer_fault_request)
        else $error("fault request missing");
    a_sample_point: assert property ($past(st_q) == ST_RECV && $changed(rxb_q)
        |-> $past(cnt_q) == SAMPLE_CNT)
        else $error("bit sampled off the 186th tick");
    a_bit_length: assert property (st_q != ST_IDLE && tick && cnt_q == BIT_LAST
        |=> cnt_q == 9'h000)
        else $error("bit period not 372 ticks");
    a_par_no_full: assert property ($rose(stat_q[SS_PER]) |-> !$rose(stat_q[SS_RX_FULL_FLAG]))
        else $error("full flag set on parity error");
    a_good_quiet: assert property (st_q == ST_RECV && !bad_q |=> !tx_data_pin_oe)
        else $error("line driven after good character");
    a_error_pulse: assert property (s_err_begin |=> tx_data_pin_oe ##1 tx_data_pin_oe)
        else $error("error pulse not driven");
endmodule
`default_nettype wire

/* include/scst_pkg.sv */
// constants for the smart card serial transfer block
package scst_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_DIV = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_TXD = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_RXD = 8'h14;
    localparam logic [7:0] OFS_CARD = 8'h18;
    // mode register fields
    localparam int MD_ODD = 4;
    localparam int MD_CKS = 0;
    // control register fields
    localparam int CT_TIE = 7;
    localparam int CT_RIE = 6;
    localparam int CT_TE = 5;
    localparam int CT_RE = 4;
    localparam int CT_CKO = 0;
    // status register fields
    localparam int SS_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int SS_RX_FULL_FLAG = 6;
    localparam int SS_OVERRUN_FLAG = 5;
    localparam int SS_ERS = 4;
    localparam int SS_PER = 3;
    localparam int SS_TX_DONE_FLAG = 2;
    localparam logic [7:0] SS_SWCLR = 8'hF8;
    // card mode register fields
    localparam int CD_BIT_ORDER_SELECT = 3;
    localparam int CD_DATA_INVERT_SELECT = 2;
    localparam int CD_CARD_MODE_SELECT = 0;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CARD_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h84;
    // bit timing in base clock ticks
    localparam logic [8:0] BIT_TICKS = 9'h174;
    localparam logic [8:0] BIT_LAST = BIT_TICKS - 9'h001;
    localparam logic [8:0] SAMPLE_CNT = 9'h0B9;
    localparam logic [8:0] HALF_CNT = 9'h0BA;
    // frame slots: start 0, data 1..8, parity 9, error window 10..11
    localparam logic [3:0] SLOT_PAR = 4'h9;
    localparam logic [3:0] SLOT_ERR = 4'hA;
    localparam logic [3:0] SLOT_CHK = 4'hB;
    localparam logic [3:0] SLOT_END = 4'hC;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_RECV = 2'b10
    } scst_state_t;
endpackage

/* tb/scst_card.sv */
// behavioural smart card on the shared, pulled-up data line
`timescale 1ns/1ns
`default_nettype none
module scst_card #(
    parameter int BIT = 744
)(
    // clock and line
    input wire logic clk,
    input wire logic line,
    // high pulls the line low
    output logic card_low
);
    logic err_seen;
    logic par_ok;

    initial card_low = 1'b0;

    task automatic send_char(input logic [7:0] d, input logic bad);
        logic [9:0] f;
        f = {^d ^ bad, d, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            card_low <= !f[i];
            repeat (BIT) @(posedge clk);
        end
        card_low <= 1'b0;
        // look for the error pulse one bit after parity, at the slot 10/11 boundary mid pulse
        repeat (BIT) @(posedge clk);
        err_seen = !line;
        repeat (BIT * 2) @(posedge clk);
    endtask

    task automatic recv_char(input logic nack, output logic [7:0] d);
        logic [8:0] s;
        @(posedge clk);
        while (line)
            @(posedge clk);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT) @(posedge clk);
            s[i] = line;
        end
        d = s[7:0];
        par_ok = !(^s);
        if (nack)
        begin
            repeat (BIT) @(posedge clk);
            card_low <= 1'b1;
            repeat (BIT) @(posedge clk);
            card_low <= 1'b0;
        end
        else
            repeat (BIT * 4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* tb/smart_card_serial_transfer_tb.sv */
// self-checking bench for the smart card transfer block
`timescale 1ns/1ns
`default_nettype none
module smart_card_serial_transfer_tb
    import scst_pkg::*;
;
    typedef struct {
        logic w;
        logic [7:0] a;
        logic [7:0] d;
        logic [31:0] x;
        logic err;
    } scst_row_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_o, tx_oe, ck_o, ck_oe;
    logic txe_rq, rxf_rq, flt_rq, end_rq, card_low, e;
    logic [31:0] r;
    logic [7:0] rx_byte;
    wire line;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    // register accesses after reset: write, addr, data, expected read, error
    scst_row_t rows[12] = '{
        '{1'b0, OFS_MODE, 8'h00, 32'h00, 1'b0},
        '{1'b0, OFS_DIV, 8'h00, 32'h00, 1'b0},
        '{1'b0, OFS_CTRL, 8'h00, 32'h00, 1'b0},
        '{1'b0, OFS_CARD, 8'h00, 32'h00, 1'b0},
        '{1'b0, OFS_STAT, 8'h00, 32'h84, 1'b0},
        '{1'b0, OFS_RXD, 8'h00, 32'h00, 1'b0},
        '{1'b0, 8'h1C, 8'h00, 32'h00, 1'b1},
        '{1'b1, OFS_DIV, 8'hAA, 32'h00, 1'b0},
        '{1'b0, OFS_DIV, 8'h00, 32'hAA, 1'b0},
        '{1'b1, OFS_RXD, 8'h5A, 32'h00, 1'b0},
        '{1'b0, OFS_RXD, 8'h00, 32'h00, 1'b0},
        '{1'b1, OFS_DIV, 8'h00, 32'h00, 1'b0}
    };

    // open-drain line with pull-up
    assign line = !(tx_oe || card_low);

    always #50 pclk = ~pclk;

    scst_core uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_data_pin(line),
        .tx_data_pin_o(tx_o), .tx_data_pin_oe(tx_oe),
        .serial_clock_pin_o(ck_o), .serial_clock_pin_oe(ck_oe),
        .tx_empty_request(txe_rq), .rx_full_request(rxf_rq),
        .transfer_fault_request(flt_rq), .tx_end_request(end_rq)
    );

    scst_card #(.BIT(744)) card (.clk(pclk), .line(line), .card_low(card_low));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic flag(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            mismatches++;
            wrap_up;
        end
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
            if (!rows[i].w)
            begin
                chk(r, rows[i].x);
                flag(e, rows[i].err);
            end
        end
        $display("test registers done");
        // stop, clear flags, configure card mode with clock out
        wr(OFS_CTRL, 8'h00);
        wr(OFS_STAT, 8'h80);
        wr(OFS_MODE, 8'h00);
        wr(OFS_CARD, 8'h01);
        wr(OFS_CTRL, 8'h01);
        // clock enable reaches the pin one edge after the write lands
        repeat (2) @(posedge pclk);
        flag(tx_oe, 1'b0);
        flag(tx_o, 1'b0);
        flag(ck_oe, 1'b1);
        // base clock toggles every pclk with the fastest divisor set
        e = ck_o;
        @(posedge pclk);
        flag(ck_o, !e);
        repeat (744) @(posedge pclk);
        wr(OFS_CTRL, 8'h51);
        card.send_char(8'hA5, 1'b0);
        flag(card.err_seen, 1'b0);
        flag(rxf_rq, 1'b1);
        rd(OFS_STAT, 32'hC4);
        rd(OFS_RXD, 32'hA5);
        card.send_char(8'h5A, 1'b0);
        rd(OFS_STAT, 32'hE4);
        rd(OFS_RXD, 32'hA5);
        wr(OFS_STAT, 8'h98);
        card.send_char(8'h3C, 1'b1);
        flag(card.err_seen, 1'b1);
        flag(flt_rq, 1'b1);
        rd(OFS_STAT, 32'h8C);
        rd(OFS_RXD, 32'h3C);
        wr(OFS_STAT, 8'hF7);
        // inverse convention: msb first, inverted data, odd parity
        wr(OFS_CTRL, 8'h01);
        wr(OFS_MODE, 8'h10);
        wr(OFS_CARD, 8'h0D);
        repeat (744) @(posedge pclk);
        wr(OFS_CTRL, 8'h51);
        card.send_char(8'h03, 1'b1);
        flag(card.err_seen, 1'b0);
        rd(OFS_STAT, 32'hC4);
        rd(OFS_RXD, 32'h3F);
        wr(OFS_STAT, 8'hB8);
        $display("test receive done");
        // turn round to sending
        wr(OFS_CTRL, 8'h01);
        wr(OFS_MODE, 8'h00);
        wr(OFS_CARD, 8'h01);
        repeat (744) @(posedge pclk);
        wr(OFS_CTRL, 8'hA1);
        repeat (2) @(posedge pclk);
        flag(txe_rq, 1'b1);
        fork
            card.recv_char(1'b1, rx_byte);
            begin
                wr(OFS_TXD, 8'hC3);
                wr(OFS_STAT, 8'h78);
            end
        join
        chk({24'h0, rx_byte}, 32'hC3);
        flag(card.par_ok, 1'b1);
        rd(OFS_STAT, 32'h90);
        flag(flt_rq, 1'b0);
        flag(txe_rq, 1'b0);
        wr(OFS_STAT, 8'hE8);
        card.recv_char(1'b0, rx_byte);
        chk({24'h0, rx_byte}, 32'hC3);
        rd(OFS_STAT, 32'h84);
        flag(txe_rq, 1'b1);
        flag(end_rq, 1'b0);
        $display("test transmit done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_STAT, 32'h84);
        rd(OFS_CTRL, 32'h00);
        flag(ck_oe, 1'b0);
        $display("test reset done");
        wrap_up;
    end
endmodule
`default_nettype wire
